// ===== rtl/mbx_pkg.sv
// Types shared by the query responder
package mbx_pkg;
    typedef struct packed {
        logic [7:0] slave;
        logic [7:0] func;
        logic [15:0] addr;
        logic [15:0] value;
        logic frame_err;
    } mbx_query_t;
    typedef struct packed {
        logic [7:0] slave;
        logic [7:0] func;
        logic [7:0] code;
        logic [15:0] data;
        logic [15:0] crc;
        logic is_exc;
    } mbx_resp_t;
    typedef enum logic [1:0] {
        MBX_DEC_NONE = 2'd0,
        MBX_DEC_ONE = 2'd1,
        MBX_DEC_TWO = 2'd2
    } mbx_dec_t;
    typedef enum logic [1:0] {
        MBX_L2_SETPOINT = 2'd0,
        MBX_L2_PV_WITH_LABEL = 2'd1,
        MBX_L2_PV_WITHOUT_LABEL = 2'd2
    } mbx_line2_t;
    typedef enum logic [2:0] {
        MBX_ST_IDLE = 3'b001,
        MBX_ST_CRC = 3'b010,
        MBX_ST_SEND = 3'b100
    } mbx_state_t;
endpackage

// ===== rtl/mbx_regs.svh
// Register offsets, codes and limits of the query responder
`ifndef MBX_REGS_SVH
`define MBX_REGS_SVH
`define MBX_REG_TEMP_UNIT 16'h0081
`define MBX_REG_DEC_PLACE 16'h009b
`define MBX_REG_TC_CHECK 16'h009f
`define MBX_REG_MAINS 16'h00a6
`define MBX_REG_LINE2_DIS 16'h00ae
`define MBX_REG_LINE2 16'h00af
`define MBX_REG_LANG 16'h00c0
`define MBX_MAX_TEMP_UNIT 16'h0002
`define MBX_MAX_DEC_PLACE 16'h0002
`define MBX_MAX_BOOL 16'h0001
`define MBX_MAX_LINE2 16'h0002
`define MBX_MAX_LANG 16'h0005
`define MBX_EXC_FLAG 8'h80
`define MBX_FC_READ 8'h03
`define MBX_FC_WRITE 8'h06
`define MBX_FC_FILE_READ 8'h14
`define MBX_EX_FUNC 8'h01
`define MBX_EX_ADDR 8'h02
`define MBX_EX_VALUE 8'h03
`define MBX_EX_FAIL 8'h04
`define MBX_EX_BUSY 8'h06
`define MBX_EX_NAK 8'h07
`define MBX_EX_OVFL 8'h09
`define MBX_RESP_BUF 16'h0040
`define MBX_CRC_INIT 16'hffff
`define MBX_CRC_POLY 16'ha001
`endif

// ===== rtl/mbx_responder.sv
// Query decoder, display set-up registers and response builder
//
// What this block does
// - Normal response echoes the query's function code.
// - Queries with parity, LRC or CRC error are dropped silently.
// - Exception response sets function code MSB, adding 80 hex.
// - Exception carries a reason code in the code field; data is zero.
// - Unsupported function answers exception 01.
// - Unknown register address answers exception 02.
// - Out-of-range write value answers exception 03.
// - Internal fault on valid message answers exception 04.
// - Query while busy is rejected with exception 06.
// - Unprocessable message answers negative acknowledge 07.
// - Function 20 oversized read answers exception 09.
// - Decimal place register: 0 none, 1 one, 2 two places.
// - Second line: 0 setpoint, 1 PV with label, 2 without.
`timescale 1ns/10ps
`include "mbx_regs.svh"
module mbx_responder (
    input wire logic clk,
    input wire logic srst,
    input wire logic query_valid,
    input wire mbx_pkg::mbx_query_t query,
    input wire logic dev_fault,
    input wire logic dev_busy,
    input wire logic dev_nak,
    output logic resp_valid,
    output mbx_pkg::mbx_resp_t resp,
    output logic [1:0] dec_place,
    output logic [1:0] line2_sel,
    output logic [1:0] temp_unit,
    output logic mains_50hz,
    output logic line2_off,
    output logic tc_check_off,
    output logic [2:0] lang_sel
);
    import mbx_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One byte folded into a Modbus CRC; used for every response byte
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MBX_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [15:0] temp_ff, dec_ff, tc_ff, mains_ff, l2dis_ff, l2_ff, lang_ff;
    mbx_state_t state_ff;
    mbx_resp_t resp_ff;
    logic [15:0] crc_ff;
    logic [2:0] idx_ff;

    wire is_read = query.func == `MBX_FC_READ;
    wire is_write = query.func == `MBX_FC_WRITE;
    wire is_file = query.func == `MBX_FC_FILE_READ;
    wire addr_hit = query.addr == `MBX_REG_TEMP_UNIT || query.addr == `MBX_REG_DEC_PLACE
        || query.addr == `MBX_REG_TC_CHECK || query.addr == `MBX_REG_MAINS
        || query.addr == `MBX_REG_LINE2_DIS || query.addr == `MBX_REG_LINE2
        || query.addr == `MBX_REG_LANG;
    // Range limit per register; enum codes above limit are refused
    wire [15:0] max_val = (query.addr == `MBX_REG_LANG) ? `MBX_MAX_LANG :
        (query.addr == `MBX_REG_DEC_PLACE) ? `MBX_MAX_DEC_PLACE :
        (query.addr == `MBX_REG_LINE2) ? `MBX_MAX_LINE2 :
        (query.addr == `MBX_REG_TEMP_UNIT) ? `MBX_MAX_TEMP_UNIT : `MBX_MAX_BOOL;
    wire value_bad = is_write && query.value > max_val;
    // Function 20 value field is the register count; buffer holds that many words
    wire file_big = is_file && query.value > `MBX_RESP_BUF;
    wire [15:0] rd_data = (query.addr == `MBX_REG_TEMP_UNIT) ? temp_ff :
        (query.addr == `MBX_REG_DEC_PLACE) ? dec_ff :
        (query.addr == `MBX_REG_TC_CHECK) ? tc_ff :
        (query.addr == `MBX_REG_MAINS) ? mains_ff :
        (query.addr == `MBX_REG_LINE2_DIS) ? l2dis_ff :
        (query.addr == `MBX_REG_LINE2) ? l2_ff : lang_ff;

    // Priority: busy, nak and fault first since the device cannot judge the rest
    wire [7:0] exc_code = dev_busy ? `MBX_EX_BUSY :
        dev_nak ? `MBX_EX_NAK :
        dev_fault ? `MBX_EX_FAIL :
        (!(is_read || is_write || is_file)) ? `MBX_EX_FUNC :
        file_big ? `MBX_EX_OVFL :
        (is_file || !addr_hit) ? `MBX_EX_ADDR :
        value_bad ? `MBX_EX_VALUE : 8'h00;
    wire is_exc = exc_code != 8'h00;
    wire take = query_valid && !query.frame_err && state_ff == MBX_ST_IDLE;
    wire do_write = take && !is_exc && is_write;

    // ------------------------------------------------------------
    // Set-up registers
    // ------------------------------------------------------------
    // Writes only land after every check passed, so stored codes stay legal
    always_ff @(posedge clk) begin
        if (srst) begin
            temp_ff <= 16'h0000;
            dec_ff <= 16'h0000;
            tc_ff <= 16'h0000;
            mains_ff <= 16'h0000;
            l2dis_ff <= 16'h0000;
            l2_ff <= 16'h0000;
            lang_ff <= 16'h0000;
        end else if (do_write) begin
            if (query.addr == `MBX_REG_TEMP_UNIT) temp_ff <= query.value;
            if (query.addr == `MBX_REG_DEC_PLACE) dec_ff <= query.value;
            if (query.addr == `MBX_REG_TC_CHECK) tc_ff <= query.value;
            if (query.addr == `MBX_REG_MAINS) mains_ff <= query.value;
            if (query.addr == `MBX_REG_LINE2_DIS) l2dis_ff <= query.value;
            if (query.addr == `MBX_REG_LINE2) l2_ff <= query.value;
            if (query.addr == `MBX_REG_LANG) lang_ff <= query.value;
        end
    end

    // Decoded set-up outputs
    assign temp_unit = temp_ff[1:0];
    assign dec_place = dec_ff[1:0];
    assign tc_check_off = tc_ff[0];
    assign mains_50hz = mains_ff[0];
    assign line2_off = l2dis_ff[0];
    assign line2_sel = l2_ff[1:0];
    assign lang_sel = lang_ff[2:0];

    // ------------------------------------------------------------
    // Response builder
    // ------------------------------------------------------------
    // Bytes fed to the CRC: slave, func, then code or two data bytes
    wire [7:0] crc_in = (idx_ff == 3'd0) ? resp_ff.slave :
        (idx_ff == 3'd1) ? resp_ff.func :
        resp_ff.is_exc ? resp_ff.code :
        (idx_ff == 3'd2) ? resp_ff.data[15:8] : resp_ff.data[7:0];
    wire [2:0] last_idx = resp_ff.is_exc ? 3'd2 : 3'd3;

    // One byte of CRC per cycle keeps the loop short at 125 MHz
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= MBX_ST_IDLE;
            resp_ff <= '0;
            crc_ff <= `MBX_CRC_INIT;
            idx_ff <= 3'd0;
        end else begin
            case (state_ff)
                MBX_ST_IDLE: begin
                    if (take) begin
                        resp_ff.slave <= query.slave;
                        resp_ff.func <= is_exc ? (query.func | `MBX_EXC_FLAG) : query.func;
                        resp_ff.code <= exc_code;
                        resp_ff.data <= is_exc ? 16'h0000 : (is_write ? query.value : rd_data);
                        resp_ff.crc <= 16'h0000;
                        resp_ff.is_exc <= is_exc;
                        crc_ff <= `MBX_CRC_INIT;
                        idx_ff <= 3'd0;
                        state_ff <= MBX_ST_CRC;
                    end
                end
                MBX_ST_CRC: begin
                    crc_ff <= crc_byte(crc_ff, crc_in);
                    idx_ff <= idx_ff + 3'd1;
                    if (idx_ff == last_idx) begin
                        resp_ff.crc <= crc_byte(crc_ff, crc_in);
                        state_ff <= MBX_ST_SEND;
                    end
                end
                MBX_ST_SEND: begin
                    state_ff <= MBX_ST_IDLE;
                end
                default: begin
                    state_ff <= MBX_ST_IDLE;
                end
            endcase
        end
    end

    // Response stands one cycle; the master handles silence itself
    assign resp_valid = state_ff == MBX_ST_SEND;
    assign resp = resp_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_drop_bad;
        @(posedge clk) disable iff (srst)
        (query_valid && query.frame_err && state_ff == MBX_ST_IDLE) |=> state_ff == MBX_ST_IDLE;
    endproperty
    a_drop_bad: assert property (p_drop_bad) else $error("bad frame answered");

    property p_echo;
        @(posedge clk) disable iff (srst)
        (take && !is_exc) |-> ##5 (resp_valid && resp.func == $past(query.func, 5));
    endproperty
    a_echo: assert property (p_echo) else $error("normal func not echoed");

    property p_exc_flag;
        @(posedge clk) disable iff (srst)
        resp_valid && resp.is_exc |-> resp.func[7] && resp.code != 8'h00;
    endproperty
    a_exc_flag: assert property (p_exc_flag) else $error("exception lacks msb or code");

    property p_exc_time;
        @(posedge clk) disable iff (srst)
        (take && is_exc) |-> ##4 (resp_valid && resp.is_exc);
    endproperty
    a_exc_time: assert property (p_exc_time) else $error("exception late");

    property p_busy;
        @(posedge clk) disable iff (srst)
        (take && dev_busy) |=> resp_ff.code == `MBX_EX_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not 06");

    property p_func;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && !dev_nak && !dev_fault && !is_read && !is_write && !is_file)
        |=> resp_ff.code == `MBX_EX_FUNC;
    endproperty
    a_func: assert property (p_func) else $error("illegal function not 01");

    property p_addr;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && !dev_nak && !dev_fault && (is_read || is_write) && !addr_hit)
        |=> resp_ff.code == `MBX_EX_ADDR;
    endproperty
    a_addr: assert property (p_addr) else $error("bad address not 02");

    property p_range;
        @(posedge clk) disable iff (srst)
        resp_valid |-> dec_ff <= 16'h0002 && l2_ff <= 16'h0002;
    endproperty
    a_range: assert property (p_range) else $error("display code out of range");

    // Refused queries must not disturb the stored decimal place, second line, language and unit codes
    property p_exc_keep;
        @(posedge clk) disable iff (srst)
        (take && is_exc) |=> dec_ff == $past(dec_ff) && l2_ff == $past(l2_ff)
            && lang_ff == $past(lang_ff) && temp_ff == $past(temp_ff);
    endproperty
    a_exc_keep: assert property (p_exc_keep) else $error("refused write stored");

    // Write above the register's limit on a healthy device
    property p_value;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && !dev_nak && !dev_fault && is_write && addr_hit
            && query.value > max_val) |=> resp_ff.code == `MBX_EX_VALUE;
    endproperty
    a_value: assert property (p_value) else $error("bad value not 03");

    // Fault only matters once busy and nak are out of the way
    property p_fault;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && !dev_nak && dev_fault) |=> resp_ff.code == `MBX_EX_FAIL;
    endproperty
    a_fault: assert property (p_fault) else $error("device fault not 04");

    // Negative acknowledge outranks everything but busy
    property p_nak;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && dev_nak) |=> resp_ff.code == `MBX_EX_NAK;
    endproperty
    a_nak: assert property (p_nak) else $error("nak not 07");

    // Oversized function 20 request on a healthy device
    property p_ovfl;
        @(posedge clk) disable iff (srst)
        (take && !dev_busy && !dev_nak && !dev_fault && is_file
            && query.value > `MBX_RESP_BUF) |=> resp_ff.code == `MBX_EX_OVFL;
    endproperty
    a_ovfl: assert property (p_ovfl) else $error("oversize read not 09");

    // Exception carries the code, never stale data
    property p_exc_data;
        @(posedge clk) disable iff (srst)
        resp_valid && resp.is_exc |-> resp.data == 16'h0000;
    endproperty
    a_exc_data: assert property (p_exc_data) else $error("exception carries data");

    // Reply goes back under the address it was sent to
    property p_slave;
        @(posedge clk) disable iff (srst)
        take |=> resp_ff.slave == $past(query.slave);
    endproperty
    a_slave: assert property (p_slave) else $error("slave address lost");

    // Normal reply must not look like an exception to the master
    property p_normal;
        @(posedge clk) disable iff (srst)
        resp_valid && !resp.is_exc |-> !resp.func[7] && resp.code == 8'h00;
    endproperty
    a_normal: assert property (p_normal) else $error("normal reply marked");

    // Accepted decimal place write shows up on the next cycle
    property p_dec_store;
        @(posedge clk) disable iff (srst)
        (do_write && query.addr == `MBX_REG_DEC_PLACE)
            |=> dec_place == $past(query.value[1:0]);
    endproperty
    a_dec_store: assert property (p_dec_store) else $error("decimal place not stored");

    // Accepted second line write shows up on the next cycle
    property p_line2_store;
        @(posedge clk) disable iff (srst)
        (do_write && query.addr == `MBX_REG_LINE2)
            |=> line2_sel == $past(query.value[1:0]);
    endproperty
    a_line2_store: assert property (p_line2_store) else $error("second line not stored");
endmodule

// ===== sim/mbx_master.sv
// Modbus master model: sends one query, then waits for a reply or times out
`timescale 1ns/10ps
module mbx_master (
    input wire logic clk,
    input wire logic go,
    input wire mbx_pkg::mbx_query_t q,
    input wire logic resp_valid,
    input wire mbx_pkg::mbx_resp_t resp,
    output logic query_valid,
    output mbx_pkg::mbx_query_t query,
    output logic done,
    output logic timed_out,
    output logic exc_seen
);
    import mbx_pkg::*;
    int cnt;
    initial begin
        {query_valid, done, timed_out, exc_seen, cnt} = '0;
        query = '0;
    end
    // ----------------------------------------
    // Query strobe and reply watch
    // ----------------------------------------
    // Released query lines toggle, so a stale query never looks valid
    always @(posedge clk) begin
        query_valid <= go;
        query <= go ? q : ~query;
        if (go) begin
            {done, timed_out} <= 2'b00;
            cnt <= 1;
        end else if (cnt > 0) begin
            cnt <= cnt + 1;
            if (resp_valid) begin
                done <= 1'b1;
                exc_seen <= resp.func[7]; // Top bit marks an exception
                cnt <= 0;
            end else if (cnt == 12) begin
                timed_out <= 1'b1; // Silence is handled here
                cnt <= 0;
            end
        end
    end
endmodule

// ===== sim/mbx_responder_tb.sv
// Self-checking bench for the query responder
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module mbx_responder_tb;
    import mbx_pkg::*;
    logic clk, srst, go, query_valid, resp_valid, dev_fault, dev_busy, dev_nak;
    logic done, timed_out, exc_seen, mains_50hz, line2_off, tc_check_off;
    logic [1:0] dec_place, line2_sel, temp_unit;
    logic [2:0] lang_sel;
    logic [31:0] seed = 32'heb1c;
    mbx_query_t q, query;
    mbx_resp_t resp;
    int miscompares = 0, compares = 0, rg[int];
    int ads[7] = '{'h81, 'h9b, 'h9f, 'ha6, 'hae, 'haf, 'hc0};
    mbx_responder u_dut (.clk(clk), .srst(srst), .query_valid(query_valid), .query(query),
        .dev_fault(dev_fault), .dev_busy(dev_busy), .dev_nak(dev_nak), .resp_valid(resp_valid),
        .resp(resp), .dec_place(dec_place), .line2_sel(line2_sel), .temp_unit(temp_unit),
        .mains_50hz(mains_50hz), .line2_off(line2_off), .tc_check_off(tc_check_off),
        .lang_sel(lang_sel));
    mbx_master u_master (.clk(clk), .go(go), .q(q), .resp_valid(resp_valid), .resp(resp),
        .query_valid(query_valid), .query(query), .done(done), .timed_out(timed_out),
        .exc_seen(exc_seen));
    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int lim(int a);
        case (a)
            'h81, 'h9b, 'haf: return 2;
            'h9f, 'ha6, 'hae: return 1;
            'hc0: return 5;
            default: return -1;
        endcase
    endfunction
    function automatic int rv(int a);
        return rg.exists(a) ? rg[a] : 0;
    endfunction
    function automatic logic [15:0] crc(int b[$]);
        logic [15:0] c = 16'hffff;
        foreach (b[i]) begin
            c ^= 16'(b[i] & 'hff);
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // One query, full reply check; flags held until the reply is in
    task automatic send(int f, int a, int v, int fe, int bz, int nk, int ft);
        int ec, sl, d;
        logic [15:0] cr;
        sl = rnd() & 'hff;
        ec = bz ? 6 : nk ? 7 : ft ? 4 : (f != 3 && f != 6 && f != 20) ? 1 :
            (f == 20 && v > 64) ? 9 : (f == 20 || lim(a) < 0) ? 2 :
            (f == 6 && v > lim(a)) ? 3 : 0;
        @(posedge clk);
        go <= 1'b1;
        q <= '{sl[7:0], f[7:0], a[15:0], v[15:0], fe[0]};
        {dev_busy, dev_nak, dev_fault} <= {bz[0], nk[0], ft[0]};
        @(posedge clk);
        go <= 1'b0;
        repeat (20) begin
            @(negedge clk);
            if (done || timed_out) break;
        end
        @(posedge clk);
        {dev_busy, dev_nak, dev_fault} <= 3'b000;
        if (fe) begin
            `CHK("silence", 2'b01, {done, timed_out})
        end else begin
            if (ec == 0 && f == 6) rg[a] = v;
            d = (f == 6) ? v : rv(a);
            cr = ec ? crc('{sl, f | 'h80, ec}) : crc('{sl, f, d >> 8, d & 'hff});
            `CHK("done", 1'b1, done)
            `CHK("slave", sl[7:0], resp.slave)
            `CHK("func", f | (ec ? 'h80 : 0), resp.func)
            `CHK("is_exc", ec != 0, resp.is_exc)
            `CHK("exc_seen", ec != 0, exc_seen)
            if (ec) `CHK("code", ec, resp.code)
            else `CHK("data", d, resp.data)
            if (ec) `CHK("exc_data", 0, resp.data)
            `CHK("crc", cr, resp.crc)
        end
        `CHK("dec_place", rv('h9b), dec_place)
        `CHK("line2_sel", rv('haf), line2_sel)
        `CHK("temp_unit", rv('h81), temp_unit)
        `CHK("flags", {3'(rv('hc0)), 1'(rv('ha6)), 1'(rv('hae)), 1'(rv('h9f))},
            {lang_sel, mains_50hz, line2_off, tc_check_off})
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and scenarios
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run needs about a thousand cycles; this bound cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        logic [31:0] r;
        {srst, go, dev_fault, dev_busy, dev_nak} = 5'b10000;
        q = '0;
        repeat (10) @(posedge clk);
        `CHK("rst_resp", '0, {resp_valid, resp})
        srst <= 1'b0;
        // Every code of every register, one out of range, then a random legal one
        foreach (ads[i]) begin
            send(3, ads[i], 0, 0, 0, 0, 0);
            for (int v = 0; v <= lim(ads[i]) + 1; v++) send(6, ads[i], v, 0, 0, 0, 0);
            send(6, ads[i], rnd() % (lim(ads[i]) + 1), 0, 0, 0, 0);
            send(3, ads[i], 0, 0, 0, 0, 0);
        end
        send(6, 'h9b, 1, 1, 0, 0, 0);
        send(3, 'h9b, 0, 1, 0, 0, 0);
        send(3, 'h50, 0, 0, 0, 0, 0);
        send(6, 'h80, 0, 0, 0, 0, 0);
        send(1, 'h81, 0, 0, 0, 0, 0);
        send('h10, 'h81, 0, 0, 0, 0, 0);
        send(20, 0, 64, 0, 0, 0, 0);
        send(20, 0, 65, 0, 0, 0, 0);
        send(6, 'h9b, 1, 0, 1, 1, 1);
        send(6, 'h9b, 1, 0, 0, 1, 1);
        send(6, 'h9b, 1, 0, 0, 0, 1);
        send(6, 'h9b, 1, 0, 0, 0, 0);
        repeat (40) begin
            r = rnd();
            send(r[1:0] == 3 ? 20 : r[0] ? 6 : 3, r[2] ? ads[r[5:3] % 7] : r[15:8], r[18:16],
                r[23] & r[24], r[25] & r[26] & r[27], r[28] & r[29], r[30] & r[31]);
        end
        give_verdict();
    end
endmodule
